// ==== spi_ctl_consts.vh ====
// constants for the serial port control, status and clock-rate block
// assumes an 8-bit special-function register port and a separate shift engine
`ifndef SPI_CTL_CONSTS_VH
`define SPI_CTL_CONSTS_VH

// register addresses
`define ADDR_CLOCK_DIVIDER 8'hA2
`define ADDR_DATA          8'hA3
`define ADDR_CONTROL       8'hF8

// control register bit positions
`define BIT_DONE      7
`define BIT_WRITE_COLLISION_FLAG      6
`define BIT_MODE_F    5
`define BIT_OVERRUN   4
`define BIT_WIRE_HI   3
`define BIT_WIRE_LO   2
`define BIT_TX_EMPTY  1
`define BIT_PORT_ON   0

// wiring modes
`define WIRE_3        2'h0
`define WIRE_4_MULTI  2'h1

// reset values
`define CONTROL_RESET 8'h06
`define DIVIDER_RESET 8'h00

`endif

// ==== tx_skid_buffer.v ====
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous flush from the owner
`timescale 1ns/100ps
module tx_skid_buffer #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk,
	input  wire             rstn,
	input  wire             flush,
	// fill side
	input  wire             inValid,
	input  wire [WIDTH-1:0] inData,
	output wire             inReady,
	// drain side
	output wire             outValid,
	output wire [WIDTH-1:0] outData,
	input  wire             outReady
);
	reg             mainValid_ff;
	reg [WIDTH-1:0] main_ff;
	reg             skidValid_ff;
	reg [WIDTH-1:0] skid_ff;

	assign inReady  = ~skidValid_ff;
	assign outValid = mainValid_ff;
	assign outData  = main_ff;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mainValid_ff <= 1'b0;
			main_ff      <= {WIDTH{1'b0}};
			skidValid_ff <= 1'b0;
			skid_ff      <= {WIDTH{1'b0}};
		end else if (flush) begin
			mainValid_ff <= 1'b0;
			skidValid_ff <= 1'b0;
		end else begin
			if (!mainValid_ff || outReady) begin
				if (skidValid_ff) begin
					main_ff      <= skid_ff;
					mainValid_ff <= 1'b1;
					skidValid_ff <= inValid;
					skid_ff      <= inData;
				end else begin
					main_ff      <= inData;
					mainValid_ff <= inValid;
				end
			end else if (inValid && !skidValid_ff) begin
				skid_ff      <= inData;
				skidValid_ff <= 1'b1;
			end
		end
	end
endmodule

// ==== sck_rate_divider.v ====
// half-period tick generator for the master serial clock
// assumes the owner toggles the clock line on every tick
`timescale 1ns/100ps
module sck_rate_divider #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk,
	input  wire             rstn,
	// control
	input  wire             run,
	input  wire [WIDTH-1:0] rate,
	// tick, one cycle, every rate+1 cycles
	output reg              tick
);
	reg [WIDTH-1:0] count_ff;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_ff <= {WIDTH{1'b0}};
			tick     <= 1'b0;
		end else if (!run) begin
			count_ff <= {WIDTH{1'b0}};
			tick     <= 1'b0;
		end else if (count_ff >= rate) begin
			count_ff <= {WIDTH{1'b0}};
			tick     <= 1'b1;
		end else begin
			count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
			tick     <= 1'b0;
		end
	end
endmodule

// ==== spi_control_rate.v ====
// control, status and clock-rate logic of the serial peripheral port
// assumes a byte-wide register port with bit writes on the control
// register, and an external shift engine that hands back done pulses
`timescale 1ns/100ps
`include "spi_ctl_consts.vh"
module spi_control_rate #(
	parameter DATA_W = 8
) (
	// clock and reset
	input  wire              clk,
	input  wire              resetn,
	// register port
	input  wire [7:0]        sfrAddr,
	input  wire              sfrWrite,
	input  wire [7:0]        sfrWdata,
	input  wire              sfrRead,
	output reg  [7:0]        sfrRdata,
	// bit write on the control register
	input  wire              bitWrite,
	input  wire [2:0]        bitIndex,
	input  wire              bitValue,
	// configuration
	input  wire              masterSelectBit,
	input  wire              interruptEnable,
	// slave select pin
	input  wire              slaveSelectIn,
	output reg               slaveSelectOut,
	output reg               slaveSelectOe,
	// shift engine side
	output wire              txValid,
	output wire [DATA_W-1:0] txData,
	input  wire              txTake,
	input  wire              engineBusy,
	input  wire              engineDone,
	input  wire [DATA_W-1:0] engineRxData,
	output reg               masterOn,
	output reg               slaveSelected,
	output reg               sckTick,
	// status
	output reg               transferInProgress,
	output reg               irq
);
	// reset release
	reg rstMeta_ff;
	reg rstn_ff;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_ff <= 1'b0;
			rstn_ff    <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstn_ff    <= rstMeta_ff;
		end
	end

	// pin and strap synchronisers
	reg selMeta_ff;
	reg sel_ff;
	reg mstMeta_ff;
	reg mst_ff;
	always @(posedge clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			selMeta_ff <= 1'b1;
			sel_ff     <= 1'b1;
			mstMeta_ff <= 1'b0;
			mst_ff     <= 1'b0;
		end else begin
			selMeta_ff <= slaveSelectIn;
			sel_ff     <= selMeta_ff;
			mstMeta_ff <= masterSelectBit;
			mst_ff     <= mstMeta_ff;
		end
	end

	// address decode, shared by read and write
	function isAddr;
		input [7:0] addr;
		input [7:0] target;
		begin
			isAddr = (addr == target);
		end
	endfunction

	// registers
	reg              done_ff;
	reg              write_collision_flag_ff;
	reg              modeFault_ff;
	reg              overrun_ff;
	reg [1:0]        wireMode_ff;
	reg              portOn_ff;
	reg [7:0]        divider_ff;
	reg [DATA_W-1:0] rxBuf_ff;
	reg              rxFull_ff;

	localparam [7:0] ctlReset = `CONTROL_RESET;

	// buffer signals
	wire bufInReady;
	wire bufEmpty = ~txValid;

	// write and read strobes
	wire ctlByteWr  = sfrWrite && isAddr(sfrAddr, `ADDR_CONTROL);
	wire divWr      = sfrWrite && isAddr(sfrAddr, `ADDR_CLOCK_DIVIDER);
	wire dataWr     = sfrWrite && isAddr(sfrAddr, `ADDR_DATA);
	wire dataRd     = sfrRead && isAddr(sfrAddr, `ADDR_DATA);

	// data write accepted only while the buffer is empty and enabled
	wire collide    = dataWr && !(bufEmpty && bufInReady);
	wire loadBuf    = dataWr && !collide && portOn_ff;

	// control register write values, byte or single bit
	reg [7:0] ctlNow;
	reg [7:0] ctlWr;
	reg [7:0] ctlWrMask;
	always @* begin
		ctlNow = {done_ff, write_collision_flag_ff, modeFault_ff, overrun_ff,
			wireMode_ff, bufEmpty, portOn_ff};
		ctlWr     = 8'h00;
		ctlWrMask = 8'h00;
		if (ctlByteWr) begin
			ctlWr     = sfrWdata;
			ctlWrMask = 8'hFF;
		end else if (bitWrite) begin
			ctlWr     = {8{bitValue}};
			ctlWrMask = 8'h01 << bitIndex;
		end
	end

	function [0:0] pick;
		input old;
		input mask;
		input val;
		begin
			pick = mask ? val : old;
		end
	endfunction

	// event conditions
	wire engDoneOn    = engineDone && portOn_ff;
	wire faultNow     = portOn_ff && mst_ff && !sel_ff
		&& (wireMode_ff == `WIRE_4_MULTI);
	wire overrunNow   = engDoneOn && !mst_ff && rxFull_ff;

	// next flag values: hardware set wins over software clear
	wire nxt_done     = engDoneOn
		| pick(done_ff, ctlWrMask[`BIT_DONE], ctlWr[`BIT_DONE]);
	wire nxt_write_collision_flag     = collide
		| pick(write_collision_flag_ff, ctlWrMask[`BIT_WRITE_COLLISION_FLAG], ctlWr[`BIT_WRITE_COLLISION_FLAG]);
	wire nxt_fault    = faultNow
		| pick(modeFault_ff, ctlWrMask[`BIT_MODE_F], ctlWr[`BIT_MODE_F]);
	wire nxt_overrun  = overrunNow
		| pick(overrun_ff, ctlWrMask[`BIT_OVERRUN], ctlWr[`BIT_OVERRUN]);

	// control and status registers
	always @(posedge clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			done_ff      <= ctlReset[`BIT_DONE];
			write_collision_flag_ff      <= ctlReset[`BIT_WRITE_COLLISION_FLAG];
			modeFault_ff <= ctlReset[`BIT_MODE_F];
			overrun_ff   <= ctlReset[`BIT_OVERRUN];
			wireMode_ff  <= ctlReset[`BIT_WIRE_HI:`BIT_WIRE_LO];
			portOn_ff    <= ctlReset[`BIT_PORT_ON];
			divider_ff   <= `DIVIDER_RESET;
		end else begin
			done_ff      <= nxt_done;
			write_collision_flag_ff      <= nxt_write_collision_flag;
			modeFault_ff <= nxt_fault;
			overrun_ff   <= nxt_overrun;
			wireMode_ff[1] <= pick(wireMode_ff[1], ctlWrMask[`BIT_WIRE_HI],
				ctlWr[`BIT_WIRE_HI]);
			wireMode_ff[0] <= pick(wireMode_ff[0], ctlWrMask[`BIT_WIRE_LO],
				ctlWr[`BIT_WIRE_LO]);
			portOn_ff    <= pick(portOn_ff, ctlWrMask[`BIT_PORT_ON],
				ctlWr[`BIT_PORT_ON]);
			if (divWr) begin
				divider_ff <= sfrWdata;
			end
		end
	end

	// receive buffer
	always @(posedge clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			rxBuf_ff  <= {DATA_W{1'b0}};
			rxFull_ff <= 1'b0;
		end else begin
			if (engDoneOn) begin
				rxBuf_ff  <= engineRxData;
				rxFull_ff <= 1'b1;
			end else if (dataRd) begin
				rxFull_ff <= 1'b0;
			end
		end
	end

	// transmit buffer; flushed while the port is off
	tx_skid_buffer #(
		.WIDTH(DATA_W)
	) txBuffer (
		.clk     (clk),
		.rstn    (rstn_ff),
		.flush   (~portOn_ff),
		.inValid (loadBuf),
		.inData  (sfrWdata[DATA_W-1:0]),
		.inReady (bufInReady),
		.outValid(txValid),
		.outData (txData),
		.outReady(txTake)
	);

	// master clock rate; a slave takes its clock from outside
	wire divTick;
	sck_rate_divider #(
		.WIDTH(8)
	) rateDivider (
		.clk (clk),
		.rstn(rstn_ff),
		.run (portOn_ff && mst_ff && engineBusy),
		.rate(divider_ff),
		.tick(divTick)
	);

	// register read data
	reg [7:0] nxt_rdata;
	always @* begin
		nxt_rdata = 8'h00;
		if (isAddr(sfrAddr, `ADDR_CONTROL)) begin
			nxt_rdata = ctlNow;
		end else if (isAddr(sfrAddr, `ADDR_CLOCK_DIVIDER)) begin
			nxt_rdata = divider_ff;
		end else if (isAddr(sfrAddr, `ADDR_DATA)) begin
			nxt_rdata = rxBuf_ff;
		end
	end

	// slave select pin and select level
	reg nxt_selOut;
	reg nxt_selOe;
	reg nxt_selected;
	always @* begin
		nxt_selOut   = 1'b1;
		nxt_selOe    = 1'b0;
		nxt_selected = 1'b0;
		if (portOn_ff) begin
			if (wireMode_ff[1]) begin
				nxt_selOut   = wireMode_ff[0];
				nxt_selOe    = 1'b1;
				nxt_selected = 1'b1;
			end else if (wireMode_ff == `WIRE_3) begin
				nxt_selected = 1'b1;
			end else begin
				nxt_selected = !sel_ff;
			end
		end
	end

	// registered outputs
	always @(posedge clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			sfrRdata           <= 8'h00;
			slaveSelectOut     <= 1'b1;
			slaveSelectOe      <= 1'b0;
			masterOn           <= 1'b0;
			slaveSelected      <= 1'b0;
			sckTick            <= 1'b0;
			transferInProgress <= 1'b0;
			irq                <= 1'b0;
		end else begin
			if (sfrRead) begin
				sfrRdata <= nxt_rdata;
			end
			slaveSelectOut     <= nxt_selOut;
			slaveSelectOe      <= nxt_selOe;
			masterOn           <= portOn_ff && mst_ff;
			slaveSelected      <= nxt_selected;
			sckTick            <= divTick;
			transferInProgress <= portOn_ff && engineBusy;
			irq                <= interruptEnable && (done_ff || write_collision_flag_ff
				|| modeFault_ff || overrun_ff);
		end
	end
endmodule

// ==== spi_engine_model.sv ====
// shift engine model: takes a byte, stays busy, ends with a done pulse
// assumes the block offers bytes on txValid and holds them until taken
`timescale 1ns/100ps
module spi_engine_model (
	// clock and test control
	input  wire       clk,
	input  wire       stall,
	// block side
	input  wire       txValid,
	input  wire [7:0] txData,
	output reg        txTake,
	output reg        engineBusy,
	output reg        engineDone,
	output reg  [7:0] engineRxData
);
	integer count = 0;
	initial begin
		txTake = 1'b0;
		engineBusy = 1'b0;
		engineDone = 1'b0;
		engineRxData = 8'h00;
	end
	always @(posedge clk) begin
		txTake <= 1'b0;
		engineDone <= 1'b0;
		if (engineBusy) begin
			count <= count - 1;
			if (count == 1) begin
				engineBusy <= 1'b0;
				engineDone <= 1'b1;
			end
		end else if (txValid && !txTake && !stall) begin
			txTake <= 1'b1;
			engineBusy <= 1'b1;
			count <= 20;
			engineRxData <= ~txData;
		end
	end
endmodule

// ==== spi_ctl_checker.sv ====
// port assertions for the control and rate block
// assumes the register map of the block header
`timescale 1ns/100ps
`include "spi_ctl_consts.vh"
module spi_ctl_checker #(
	parameter DATA_W = 8
) (
	// clock and reset
	input logic              clk,
	input logic              resetn,
	// register port
	input logic              sfrWrite,
	input logic              sfrRead,
	input logic              bitWrite,
	input logic [7:0]        sfrAddr,
	input logic [7:0]        sfrWdata,
	input logic [7:0]        sfrRdata,
	// shift engine side
	input logic              txValid,
	input logic [DATA_W-1:0] txData,
	input logic              txTake,
	input logic              engineBusy,
	input logic              engineDone,
	// status
	input logic              interruptEnable,
	input logic              masterOn,
	input logic              sckTick,
	input logic              transferInProgress,
	input logic              irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [7:0] div_ff;
	logic [7:0] gap_ff;
	logic       runOk_ff;
	logic       prevOk_ff;
	wire divWr = sfrWrite && sfrAddr == `ADDR_CLOCK_DIVIDER;
	wire dataWr = sfrWrite && sfrAddr == `ADDR_DATA;
	// the counter runs one edge ahead of the registered tick, so look one cycle back too
	wire runNow = masterOn && engineBusy && !divWr && prevOk_ff;
	// divider copy, cycles since last tick, run unbroken since last tick
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_ff <= 8'h00;
			gap_ff <= 8'h00;
			runOk_ff <= 1'b0;
			prevOk_ff <= 1'b0;
		end else begin
			div_ff <= divWr ? sfrWdata : div_ff;
			gap_ff <= sckTick ? 8'h00 : gap_ff + 8'h01;
			runOk_ff <= sckTick ? runNow : runOk_ff && runNow;
			prevOk_ff <= engineBusy && !divWr;
		end
	end
	sequence doneSeen;
		engineDone && masterOn && interruptEnable ##1 interruptEnable;
	endsequence
	sequence quietRegs;
		!sfrWrite && !bitWrite && !$past(sfrWrite) && !$past(bitWrite);
	endsequence
	AST_DONE_IRQ: assert property (doneSeen |=> irq)
		else $error("no irq after transfer end");
	AST_IRQ_HOLD: assert property (irq && interruptEnable ##0 quietRegs |=> irq)
		else $error("flag dropped without software");
	AST_IRQ_MASK: assert property (!interruptEnable |=> !irq)
		else $error("irq while disabled");
	AST_TX_LOAD: assert property (dataWr && masterOn && !txValid |=> txValid)
		else $error("data write not buffered");
	AST_WRITE_COLLISION_FLAG_DROP: assert property (dataWr && txValid && !txTake |=>
		txValid && $stable(txData))
		else $error("colliding write changed buffer");
	AST_TX_TAKE: assert property (txValid && txTake |=> !txValid)
		else $error("buffer not emptied on take");
	AST_RATE: assert property (sckTick && runOk_ff |-> gap_ff == div_ff)
		else $error("tick spacing wrong");
	AST_SLAVE_NO_TICK: assert property (!masterOn ##1 !masterOn |=> !sckTick)
		else $error("tick without master");
	AST_BUSY: assert property (engineBusy && masterOn |=> transferInProgress)
		else $error("busy not shown");
	AST_DIV_READ: assert property (sfrRead && !divWr
		&& sfrAddr == `ADDR_CLOCK_DIVIDER |=> sfrRdata == div_ff)
		else $error("divider readback wrong");
endmodule
bind spi_control_rate spi_ctl_checker #(.DATA_W(DATA_W)) chk (.clk(clk), .resetn(resetn),
	.sfrWrite(sfrWrite), .sfrRead(sfrRead), .bitWrite(bitWrite), .sfrAddr(sfrAddr),
	.interruptEnable(interruptEnable), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
	.txValid(txValid), .txTake(txTake), .engineBusy(engineBusy), .engineDone(engineDone),
	.masterOn(masterOn), .sckTick(sckTick), .transferInProgress(transferInProgress),
	.irq(irq), .txData(txData));

// ==== spi_control_and_clock_rate_tb.sv ====
// self-checking bench for the serial port control and rate block
// assumes the engine model and checker are compiled alongside
`timescale 1ns/100ps
`include "spi_ctl_consts.vh"
module spi_control_and_clock_rate_tb;
	reg clk = 1'b0, resetn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, bitWrite = 1'b0;
	reg bitValue = 1'b0, masterSelectBit = 1'b0, interruptEnable = 1'b0, slaveSelectIn = 1'b1;
	reg stall = 1'b0;
	reg [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00;
	reg [2:0] bitIndex = 3'h0;
	wire [7:0] sfrRdata, txData, engineRxData;
	wire slaveSelectOut, slaveSelectOe, txValid, txTake, engineBusy, engineDone;
	wire masterOn, slaveSelected, sckTick, transferInProgress, irq;
	integer errors = 0, n_tests = 0;
	always #10 clk = ~clk;
	spi_control_rate #(.DATA_W(8)) dut (.clk(clk), .resetn(resetn), .sfrAddr(sfrAddr),
		.sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
		.bitWrite(bitWrite), .bitIndex(bitIndex), .bitValue(bitValue),
		.masterSelectBit(masterSelectBit), .interruptEnable(interruptEnable),
		.slaveSelectIn(slaveSelectIn), .slaveSelectOut(slaveSelectOut),
		.slaveSelectOe(slaveSelectOe), .txValid(txValid), .txData(txData), .txTake(txTake),
		.engineBusy(engineBusy), .engineDone(engineDone), .engineRxData(engineRxData),
		.masterOn(masterOn), .slaveSelected(slaveSelected), .sckTick(sckTick),
		.transferInProgress(transferInProgress), .irq(irq));
	spi_engine_model eng (.clk(clk), .stall(stall), .txValid(txValid), .txData(txData),
		.txTake(txTake), .engineBusy(engineBusy), .engineDone(engineDone),
		.engineRxData(engineRxData));
	task report_and_stop;
		begin
			$display("errors %0d tests %0d", errors, n_tests);
			if (errors == 0 && n_tests > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task check(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tk(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			sfrAddr = a;
			sfrWdata = d;
			sfrWrite = 1'b1;
			tk(1);
			sfrWrite = 1'b0;
			tk(1);
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			sfrAddr = a;
			sfrRead = 1'b1;
			tk(1);
			sfrRead = 1'b0;
			check(sfrRdata, exp);
			tk(1);
		end
	endtask
	task bw(input [2:0] i, input v);
		begin
			bitIndex = i;
			bitValue = v;
			bitWrite = 1'b1;
			tk(1);
			bitWrite = 1'b0;
			tk(1);
		end
	endtask
	task waitDone;
		integer k;
		begin
			for (k = 0; k < 100 && engineDone !== 1'b1; k = k + 1)
				tk(1);
			if (engineDone !== 1'b1) begin
				errors = errors + 1;
				$display("[ERR] %0t transfer never ended", $time);
				report_and_stop;
			end
			tk(3);
		end
	endtask
	initial begin
		tk(3);
		resetn = 1'b1;
		tk(6);
		rd(`ADDR_CONTROL, `CONTROL_RESET);
		rd(`ADDR_CLOCK_DIVIDER, `DIVIDER_RESET);
		check({7'h00, slaveSelectOe}, 8'h00);
		rd(8'h00, 8'h00);
		wr(`ADDR_CLOCK_DIVIDER, 8'h05);
		rd(`ADDR_CLOCK_DIVIDER, 8'h05);
		masterSelectBit = 1'b1;
		stall = 1'b1;
		bw(`BIT_PORT_ON, 1'b1);
		tk(4);
		rd(`ADDR_CONTROL, 8'h07);
		check({6'h00, masterOn, slaveSelected}, 8'h02);
		wr(`ADDR_DATA, 8'h5A);
		rd(`ADDR_CONTROL, 8'h05);
		wr(`ADDR_DATA, 8'h33);
		rd(`ADDR_CONTROL, 8'h45);
		check(txData, 8'h5A);
		interruptEnable = 1'b1;
		stall = 1'b0;
		waitDone;
		rd(`ADDR_CONTROL, 8'hC7);
		check({7'h00, irq}, 8'h01);
		interruptEnable = 1'b0;
		tk(2);
		check({7'h00, irq}, 8'h00);
		rd(`ADDR_DATA, 8'hA5);
		tk(20);
		rd(`ADDR_CONTROL, 8'hC7);
		bw(`BIT_DONE, 1'b0);
		bw(`BIT_WRITE_COLLISION_FLAG, 1'b0);
		rd(`ADDR_CONTROL, 8'h07);
		slaveSelectIn = 1'b0;
		tk(6);
		rd(`ADDR_CONTROL, 8'h27);
		check({7'h00, slaveSelected}, 8'h01);
		slaveSelectIn = 1'b1;
		tk(3);
		bw(`BIT_MODE_F, 1'b0);
		bw(`BIT_WIRE_HI, 1'b1);
		tk(2);
		check({5'h00, slaveSelected, slaveSelectOe, slaveSelectOut}, 8'h07);
		bw(`BIT_WIRE_LO, 1'b0);
		tk(2);
		check({6'h00, slaveSelectOe, slaveSelectOut}, 8'h02);
		bw(`BIT_WIRE_HI, 1'b0);
		slaveSelectIn = 1'b0;
		tk(6);
		check({7'h00, slaveSelectOe}, 8'h00);
		rd(`ADDR_CONTROL, 8'h03);
		slaveSelectIn = 1'b1;
		tk(4);
		check({7'h00, slaveSelected}, 8'h01);
		masterSelectBit = 1'b0;
		tk(4);
		check({7'h00, masterOn}, 8'h00);
		wr(`ADDR_DATA, 8'h11);
		tk(3);
		check({7'h00, transferInProgress}, 8'h01);
		waitDone;
		check({7'h00, transferInProgress}, 8'h00);
		wr(`ADDR_DATA, 8'h22);
		waitDone;
		rd(`ADDR_CONTROL, 8'h93);
		bw(`BIT_PORT_ON, 1'b0);
		wr(`ADDR_DATA, 8'h77);
		tk(1);
		check({7'h00, txValid}, 8'h00);
		report_and_stop;
	end
endmodule
